//--- verilog/ps_timer_one.sv
// Prescale timer one control: source, divide, hold, interval and event flag
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module ps_timer_one
(
	input  wire logic                          sys_clk,
	input  wire logic                          reset_n,
	input  wire logic [ps_timer_pkg::ADDR_W-1:0] addr,
	input  wire logic [ps_timer_pkg::DATA_W-1:0] wdata,
	input  wire logic                          wr_en,
	input  wire logic                          rd_en,
	output logic      [ps_timer_pkg::DATA_W-1:0] rdata,
	input  wire logic                          xtal_tick,
	input  wire logic                          stage_one_tick,
	input  wire logic                          calendar_mode,
	input  wire logic                          global_clock_hold,
	input  wire logic                          low_power_pin_lock,
	input  wire logic                          deepest_low_power_mode,
	input  wire logic                          tamper_present,
	input  wire logic                          higher_vector_pending,
	output logic                               stage_one_force_div256,
	output logic      [2:0]                    stage_one_div_override,
	output logic                               stage_two_out_tick,
	output logic                               stage_two_irq,
	output logic                               wake_request,
	output logic                               vector_valid,
	output logic      [15:0]                   vector_code,
	output logic                               irq
);

	import ps_timer_pkg::*;

	// One strobe decode shared by all four registers
	function automatic logic reg_hit(input logic strobe,
		input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return strobe && (a == ofs);
	endfunction

	// Software visible control fields
	logic [1:0]   src_reg;
	logic [2:0]   div_reg;
	logic         hold_reg;
	logic [2:0]   ivl_reg;
	logic         ie_reg;
	logic         flag_reg;
	logic [1:0]   irq_status_reg;
	logic [1:0]   irq_mask_reg;
	logic [15:0]  rdata_reg;
	logic         lpm_prev_reg;
	logic         vec_valid_reg;
	logic [15:0]  vec_code_reg;

	// Effective settings after the retention stage
	logic [1:0]   src_eff;
	logic [2:0]   div_eff;
	logic         hold_eff;
	logic [2:0]   ivl_eff;

	// Counter side
	logic [7:0]   count_value;
	logic         div_pulse;
	logic         event_pulse;
	logic         wrap_pulse;

	// Decoded strobes and datapath terms
	logic         wr_ctrl;
	logic         wr_count;
	logic         wr_status;
	logic         wr_mask;
	logic         lpm_entry;
	logic         source_tick;
	logic         counter_held;
	logic         count_step;
	logic [2:0]   div_sel;
	logic [15:0]  ctrl_view;
	logic [15:0]  rdata_next;
	logic         flag_next;
	logic [1:0]   irq_status_next;

	assign wr_ctrl   = reg_hit(wr_en, addr, CTRL_OFS);
	assign wr_count  = reg_hit(wr_en, addr, COUNT_OFS);
	assign wr_status = reg_hit(wr_en, addr, IRQ_STATUS_OFS);
	assign wr_mask   = reg_hit(wr_en, addr, IRQ_MASK_OFS);

	// Entering the deepest mode loses the source, divide, hold and interval fields; their effect stays only while the pins are locked
	assign lpm_entry = deepest_low_power_mode && !lpm_prev_reg;

	// Edge detect idles low, matching the mode input after reset
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			lpm_prev_reg <= 1'b0;
		else
			lpm_prev_reg <= deepest_low_power_mode;
	end

	// Source, divide, hold and interval fields
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			src_reg  <= SRC_RESET;
			div_reg  <= DIV_RESET;
			hold_reg <= HOLD_RESET;
			ivl_reg  <= IVL_RESET;
		end
		else if (lpm_entry)
		begin
			src_reg  <= SRC_RESET;
			div_reg  <= DIV_RESET;
			hold_reg <= HOLD_RESET;
			ivl_reg  <= IVL_RESET;
		end
		else if (wr_ctrl)
		begin
			// Reserved positions are simply not stored
			src_reg  <= wdata[SRC_HI:SRC_LO];
			div_reg  <= wdata[DIV_HI:DIV_LO];
			hold_reg <= wdata[HOLD_BIT];
			ivl_reg  <= wdata[IVL_HI:IVL_LO];
		end
	end

	// Interrupt enable survives the deepest mode so that it can wake
	// Kept apart from the wiped fields so a pending wake is never lost
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			ie_reg <= IE_RESET;
		else if (wr_ctrl)
			ie_reg <= wdata[IE_BIT];
	end

	// A write acts one cycle late; the price of a clean freeze point
	config_retain u_retain
	(
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.pin_lock (low_power_pin_lock),
		.src_in   (src_reg),
		.div_in   (div_reg),
		.hold_in  (hold_reg),
		.ivl_in   (ivl_reg),
		.src_eff  (src_eff),
		.div_eff  (div_eff),
		.hold_eff (hold_eff),
		.ivl_eff  (ivl_eff)
	);

	// Clock source for the counter
	// The two codes of each pair are aliases with no difference
	always_comb
	begin
		source_tick = 1'b0;
		if (calendar_mode)
			source_tick = stage_one_tick;
		else
		begin
			unique case (source_sel_t'(src_eff))
				SRC_XTAL_A,
				SRC_XTAL_B:
					source_tick = xtal_tick;
				SRC_STAGE_ONE_A,
				SRC_STAGE_ONE_B:
					source_tick = stage_one_tick;
			endcase
		end
	end

	// Local hold has no say in calendar mode
	assign counter_held = calendar_mode ? global_clock_hold
		: hold_eff;
	assign count_step = source_tick && !counter_held;

	// Calendar mode pins the output divider, ignoring the field
	assign div_sel = calendar_mode ? STAGE_TWO_CAL_DIV
		: div_eff;

	// The first prescaler lives outside; in calendar mode it is told to divide by 256
	assign stage_one_force_div256 = calendar_mode;
	assign stage_one_div_override = STAGE_ONE_CAL_DIV;

	// A counter write beats a tick arriving in the same cycle
	stage_two_count u_count
	(
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.step        (count_step),
		.load        (wr_count),
		.load_value  (wdata[COUNT_W-1:0]),
		.div_sel     (div_sel),
		.ivl_sel     (ivl_eff),
		.count_value (count_value),
		.div_pulse   (div_pulse),
		.event_pulse (event_pulse),
		.wrap_pulse  (wrap_pulse)
	);

	// Feeds the calendar counters, or whatever the divided rate drives
	assign stage_two_out_tick = div_pulse;

	// Time event flag: software may write either value, an event wins
	always_comb
	begin
		flag_next = flag_reg;
		if (wr_ctrl)
			flag_next = wdata[FLAG_BIT];
		if (event_pulse)
			flag_next = 1'b1;
	end

	// Own register so the event path into the flag stays short
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			flag_reg <= FLAG_RESET;
		else
			flag_reg <= flag_next;
	end

	// Request stays up as long as flag and enable are both set
	assign stage_two_irq = flag_reg && ie_reg;

	// Level wake-up; only meaningful while in the deepest mode
	// The power controller, not this block, decides when it is heeded
	assign wake_request = flag_reg && ie_reg;

	// Vector code; the other timer sources outrank this one
	// Registered so the code word cannot glitch while requests settle
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			vec_valid_reg <= 1'b0;
			vec_code_reg  <= 16'h0000;
		end
		else
		begin
			vec_valid_reg <= stage_two_irq && !higher_vector_pending;
			vec_code_reg  <= tamper_present ? VEC_TAMPER
				: VEC_PLAIN;
		end
	end

	// Code reads zero when idle so a wired OR of sources stays clean
	assign vector_valid = vec_valid_reg;
	assign vector_code  = vec_valid_reg ? vec_code_reg : 16'h0000;

	// Sticky status for the system interrupt line, write one to clear
	always_comb
	begin
		irq_status_next = irq_status_reg;
		if (wr_status)
			irq_status_next = irq_status_reg & ~wdata[IRQ_W-1:0];
		// Set wins over a clear in the same cycle
		if (event_pulse)
			irq_status_next[IRQ_EVENT_BIT] = 1'b1;
		if (wrap_pulse)
			irq_status_next[IRQ_WRAP_BIT] = 1'b1;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			irq_status_reg <= IRQ_STATUS_RESET;
		else
			irq_status_reg <= irq_status_next;
	end

	// Mask has the same layout as status and no reserved bits
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			irq_mask_reg <= IRQ_MASK_RESET;
		else if (wr_mask)
			irq_mask_reg <= wdata[IRQ_W-1:0];
	end

	// Level output; drops only when software clears or masks
	assign irq = |(irq_status_reg & irq_mask_reg);

	// Control register as software sees it; gaps read back as zero
	always_comb
	begin
		ctrl_view = 16'h0000;
		ctrl_view[SRC_HI:SRC_LO] = src_reg;
		ctrl_view[DIV_HI:DIV_LO] = div_reg;
		ctrl_view[HOLD_BIT]      = hold_reg;
		ctrl_view[IVL_HI:IVL_LO] = ivl_reg;
		ctrl_view[IE_BIT]        = ie_reg;
		ctrl_view[FLAG_BIT]      = flag_reg;
	end

	// Read data stand for exactly one cycle after the strobe
	always_comb
	begin
		rdata_next = 16'h0000;
		if (rd_en)
		begin
			unique case (addr)
				CTRL_OFS:
					rdata_next = ctrl_view;
				COUNT_OFS:
					rdata_next = {8'h00, count_value};
				IRQ_STATUS_OFS:
					rdata_next = {14'h0000, irq_status_reg};
				IRQ_MASK_OFS:
					rdata_next = {14'h0000, irq_mask_reg};
				// Indices four to seven are unmapped
				default:
					rdata_next = 16'h0000;
			endcase
		end
	end

	// Registered read keeps the bus answer at one fixed cycle
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			rdata_reg <= RDATA_RESET;
		else
			rdata_reg <= rdata_next;
	end

	assign rdata = rdata_reg;

endmodule

//--- verilog/ps_timer_pkg.sv
// Constants, types and helpers shared by the prescale timer one design
package ps_timer_pkg;

	// Register port geometry
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int COUNT_W = 8;
	localparam int IRQ_W = 2;

	// Register offsets on the plain register port
	localparam logic [2:0] CTRL_OFS = 3'h0;
	localparam logic [2:0] COUNT_OFS = 3'h1;
	localparam logic [2:0] IRQ_STATUS_OFS = 3'h2;
	localparam logic [2:0] IRQ_MASK_OFS = 3'h3;

	// Control register field positions
	localparam int SRC_HI = 15;
	localparam int SRC_LO = 14;
	localparam int DIV_HI = 13;
	localparam int DIV_LO = 11;
	localparam int HOLD_BIT = 8;
	localparam int IVL_HI = 4;
	localparam int IVL_LO = 2;
	localparam int IE_BIT = 1;
	localparam int FLAG_BIT = 0;

	// Control register values after reset
	localparam logic [1:0] SRC_RESET = 2'h0;
	localparam logic [2:0] DIV_RESET = 3'h0;
	localparam logic HOLD_RESET = 1'b1;
	localparam logic [2:0] IVL_RESET = 3'h0;
	localparam logic IE_RESET = 1'b0;
	localparam logic FLAG_RESET = 1'b0;

	// Other registers after reset
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] IRQ_STATUS_RESET = 2'h0;
	localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

	// Interrupt status bit positions
	localparam int IRQ_EVENT_BIT = 0;
	localparam int IRQ_WRAP_BIT = 1;

	// Fixed divide taps in calendar mode: /256 for stage one, /128 here
	localparam logic [2:0] STAGE_ONE_CAL_DIV = 3'h7;
	localparam logic [2:0] STAGE_TWO_CAL_DIV = 3'h6;

	// Vector codes for the stage two event
	localparam logic [15:0] VEC_PLAIN = 16'h000c;
	localparam logic [15:0] VEC_TAMPER = 16'h000e;

	typedef enum logic [1:0] {
		SRC_XTAL_A = 2'b00,
		SRC_XTAL_B = 2'b01,
		SRC_STAGE_ONE_A = 2'b10,
		SRC_STAGE_ONE_B = 2'b11
	} source_sel_t;

	// True when the next increment carries out of tap sel (divide by 2^(sel+1))
	function automatic logic tap_hit(input logic [7:0] cnt,
		input logic [2:0] sel);
		logic [7:0] m;
		m = 8'hff >> (3'h7 - sel);
		return (cnt & m) == m;
	endfunction

endpackage

//--- verilog/stage_two_count.sv
// Eight bit stage two prescale counter with divide and interval taps
`timescale 1ns/10ps
module stage_two_count
	import ps_timer_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic         step,
	input  wire logic         load,
	input  wire logic [7:0]   load_value,
	input  wire logic [2:0]   div_sel,
	input  wire logic [2:0]   ivl_sel,
	output logic      [7:0]   count_value,
	output logic              div_pulse,
	output logic              event_pulse,
	output logic              wrap_pulse
);

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			count_value <= COUNT_RESET;
		else if (load)
			count_value <= load_value;
		else if (step)
			count_value <= count_value + 8'h01;
	end

	// Taps fire on the carry out of the chosen bit, one pulse per period
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			div_pulse   <= 1'b0;
			event_pulse <= 1'b0;
			wrap_pulse  <= 1'b0;
		end
		else
		begin
			div_pulse   <= step && !load && tap_hit(count_value, div_sel);
			event_pulse <= step && !load && tap_hit(count_value, ivl_sel);
			wrap_pulse  <= step && !load && (count_value == 8'hff);
		end
	end

endmodule

//--- verilog/config_retain.sv
// Effective copy of the retained settings, frozen while the pins are locked
`timescale 1ns/10ps
module config_retain
	import ps_timer_pkg::*;
(
	input  wire logic         sys_clk,
	input  wire logic         reset_n,
	input  wire logic         pin_lock,
	input  wire logic [1:0]   src_in,
	input  wire logic [2:0]   div_in,
	input  wire logic         hold_in,
	input  wire logic [2:0]   ivl_in,
	output logic      [1:0]   src_eff,
	output logic      [2:0]   div_eff,
	output logic              hold_eff,
	output logic      [2:0]   ivl_eff
);

	// While locked the register may be lost or rewritten; behaviour holds
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			src_eff  <= SRC_RESET;
			div_eff  <= DIV_RESET;
			hold_eff <= HOLD_RESET;
			ivl_eff  <= IVL_RESET;
		end
		else if (!pin_lock)
		begin
			src_eff  <= src_in;
			div_eff  <= div_in;
			hold_eff <= hold_in;
			ivl_eff  <= ivl_in;
		end
	end

endmodule

//--- dv/ps_timer_one_chk.sv
// Port-level assertions for prescale timer one control
`timescale 1ns/10ps
module ps_timer_one_chk
	import ps_timer_pkg::*;
(
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [2:0]  addr,
	input wire logic [15:0] wdata,
	input wire logic        wr_en,
	input wire logic        rd_en,
	input wire logic [15:0] rdata,
	input wire logic        calendar_mode,
	input wire logic        global_clock_hold,
	input wire logic        tamper_present,
	input wire logic        higher_vector_pending,
	input wire logic        stage_one_force_div256,
	input wire logic [2:0]  stage_one_div_override,
	input wire logic        stage_two_out_tick,
	input wire logic        stage_two_irq,
	input wire logic        wake_request,
	input wire logic        vector_valid,
	input wire logic [15:0] vector_code,
	input wire logic        irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_rsv;
		rd_en && addr == CTRL_OFS |=> rdata[10:9] == 0 && rdata[7:5] == 0;
	endproperty
	property p_idle;
		!rd_en |=> rdata == 16'h0000;
	endproperty
	property p_unmap;
		rd_en && addr[2] |=> rdata == 16'h0000;
	endproperty
	property p_wake;
		wake_request == stage_two_irq;
	endproperty
	property p_vvalid;
		1 |=> vector_valid ==
			($past(stage_two_irq) && !$past(higher_vector_pending));
	endproperty
	property p_vcode;
		vector_valid && $stable(tamper_present) |->
			vector_code == (tamper_present ? VEC_TAMPER : VEC_PLAIN);
	endproperty
	property p_vzero;
		!vector_valid |-> vector_code == 16'h0000;
	endproperty
	property p_cal;
		stage_one_force_div256 == calendar_mode &&
			stage_one_div_override == STAGE_ONE_CAL_DIV;
	endproperty
	property p_ghold;
		(calendar_mode && global_clock_hold) [*3] |=> !stage_two_out_tick;
	endproperty
	property p_mask;
		wr_en && addr == IRQ_MASK_OFS && wdata[1:0] == 2'h0 |=> !irq;
	endproperty
	// Only a cycle with a write strobe may drop a pending request
	property p_stick;
		stage_two_irq && !wr_en |=> stage_two_irq;
	endproperty

	a_rsv: assert property (p_rsv)
		else $error("reserved control bits not zero");
	a_idle: assert property (p_idle)
		else $error("read data not zero outside read");
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	a_wake: assert property (p_wake)
		else $error("wake request differs from request");
	a_vvalid: assert property (p_vvalid)
		else $error("vector valid wrong");
	a_vcode: assert property (p_vcode)
		else $error("vector code wrong");
	a_vzero: assert property (p_vzero)
		else $error("vector code without valid");
	a_cal: assert property (p_cal)
		else $error("stage one override wrong");
	a_ghold: assert property (p_ghold)
		else $error("output tick under global hold");
	a_mask: assert property (p_mask)
		else $error("interrupt with mask clear");
	a_stick: assert property (p_stick)
		else $error("request dropped without write");
	c_vec: cover property (vector_valid);
	c_irq: cover property (irq);
	c_cal: cover property (stage_two_out_tick && calendar_mode);
endmodule

bind ps_timer_one ps_timer_one_chk u_ps_timer_one_chk (.sys_clk, .reset_n,
	.addr, .wdata, .wr_en, .rd_en, .rdata, .calendar_mode, .global_clock_hold,
	.tamper_present, .higher_vector_pending, .stage_one_force_div256,
	.stage_one_div_override, .stage_two_out_tick, .stage_two_irq,
	.wake_request, .vector_valid, .vector_code, .irq);

//--- dv/ps_timer_one_bench.sv
// Self-checking testbench for prescale timer one control
`timescale 1ns/10ps
module ps_timer_one_bench;
	import ps_timer_pkg::*;
	logic        sys_clk = 0, reset_n = 0, wr_en = 0, rd_en = 0;
	logic        xtal_tick = 0, stage_one_tick = 0, calendar_mode = 0;
	logic        global_clock_hold = 0, low_power_pin_lock = 0;
	logic        deepest_low_power_mode = 0, tamper_present = 0;
	logic        higher_vector_pending = 0, stage_one_force_div256;
	logic        stage_two_out_tick, stage_two_irq, wake_request;
	logic        vector_valid, irq;
	logic [2:0]  addr = 0, stage_one_div_override;
	logic [15:0] wdata = 0, rdata, vector_code, v;
	int          fail_count = 0, tests_run = 0, pc = 0, cyc = 0;

	ps_timer_one u_ps_timer_one (.sys_clk, .reset_n, .addr, .wdata, .wr_en,
		.rd_en, .rdata, .xtal_tick, .stage_one_tick, .calendar_mode,
		.global_clock_hold, .low_power_pin_lock, .deepest_low_power_mode,
		.tamper_present, .higher_vector_pending, .stage_one_force_div256,
		.stage_one_div_override, .stage_two_out_tick, .stage_two_irq,
		.wake_request, .vector_valid, .vector_code, .irq);

	always #4 sys_clk = ~sys_clk;

	// Counts output ticks; also cuts a hang short
	always @(posedge sys_clk)
	begin
		cyc++;
		if (stage_two_out_tick === 1'b1)
			pc++;
		if (cyc == 60000)
		begin
			fail_count++;
			final_report;
		end
	end

	task final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] s, e);
		tests_run++;
		if (s !== e)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1;
		@(posedge sys_clk);
		wr_en <= 0;
		#1;
	endtask

	task rd(input logic [2:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1;
		@(posedge sys_clk);
		rd_en <= 0;
		#1 v = rdata;
	endtask

	// Ticks are spaced two cycles apart; one = stage one input
	task tk(input int n, input logic one);
		repeat (n)
		begin
			@(posedge sys_clk);
			xtal_tick <= !one;
			stage_one_tick <= one;
			@(posedge sys_clk);
			xtal_tick <= 0;
			stage_one_tick <= 0;
		end
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	function automatic logic [15:0] cf(input logic [1:0] s,
		input logic [2:0] d, input logic h, input logic [2:0] i,
		input logic e);
		return {s, d, 2'h0, h, 3'h0, i, e, 1'b0};
	endfunction

	// Counter starts from zero so pulse counts are exact
	task meas(input logic [15:0] c, input int n, input logic one, input int e);
		wr(CTRL_OFS, c);
		wr(COUNT_OFS, 16'h0000);
		pc = 0;
		tk(n, one);
		chk("pulses", 16'(pc), 16'(e));
	endtask

	task t_regs;
		rd(CTRL_OFS);
		chk("ctrl", v, 16'h0100);
		wr(COUNT_OFS, 16'h005a);
		rd(COUNT_OFS);
		chk("count", v, 16'h005a);
		wr(CTRL_OFS, 16'hffff);
		rd(CTRL_OFS);
		chk("ctrl", v, 16'hf91f);
		chk("req", stage_two_irq, 16'h0001);
		wr(3'h5, 16'hffff);
		rd(3'h5);
		chk("unmapped", v, 16'h0000);
		wr(CTRL_OFS, 16'h0100);
		chk("req", stage_two_irq, 16'h0000);
	endtask

	task t_source;
		meas(cf(2'h0, 3'h0, 1'b1, 3'h0, 1'b0), 8, 1'b0, 0);
		for (int s = 0; s < 4; s++)
		begin
			meas(cf(2'(s), 3'h0, 1'b0, 3'h0, 1'b0), 8, 1'b0, s < 2 ? 4 : 0);
			meas(cf(2'(s), 3'h0, 1'b0, 3'h0, 1'b0), 8, 1'b1, s < 2 ? 0 : 4);
		end
	endtask

	task t_divide;
		for (int n = 0; n < 8; n++)
		begin
			meas(cf(2'h0, 3'(n), 1'b0, 3'h0, 1'b0), 512, 1'b0, 512 >> (n + 1));
			rd(COUNT_OFS);
			chk("count", v, 16'h0000);
		end
	endtask

	task t_calendar;
		@(posedge sys_clk);
		calendar_mode <= 1;
		meas(cf(2'h0, 3'h0, 1'b1, 3'h0, 1'b0), 256, 1'b1, 2);
		chk("force", stage_one_force_div256, 16'h0001);
		chk("override", stage_one_div_override, 16'(STAGE_ONE_CAL_DIV));
		meas(cf(2'h0, 3'h0, 1'b1, 3'h0, 1'b0), 16, 1'b0, 0);
		@(posedge sys_clk);
		global_clock_hold <= 1;
		meas(cf(2'h0, 3'h0, 1'b0, 3'h0, 1'b0), 256, 1'b1, 0);
		@(posedge sys_clk);
		global_clock_hold <= 0;
		calendar_mode <= 0;
	endtask

	task t_interval;
		// Wraps from earlier scenarios are still pending in status
		wr(IRQ_STATUS_OFS, 16'h0003);
		for (int n = 0; n < 8; n++)
		begin
			@(posedge sys_clk);
			tamper_present <= n[0];
			wr(IRQ_MASK_OFS, 16'h0001);
			meas(cf(2'h0, 3'h7, 1'b0, 3'(n), 1'b1), (2 << n) - 1, 1'b0,
				0);
			chk("req", stage_two_irq, 16'h0000);
			tk(1, 1'b0);
			chk("req", stage_two_irq, 16'h0001);
			chk("irq", irq, 16'h0001);
			chk("vec", vector_code, n[0] ? VEC_TAMPER : VEC_PLAIN);
			chk("vvalid", vector_valid, 16'h0001);
			rd(IRQ_STATUS_OFS);
			chk("status", v, n == 7 ? 16'h0003 : 16'h0001);
			wr(IRQ_MASK_OFS, 16'h0000);
			chk("irq", irq, 16'h0000);
			wr(IRQ_STATUS_OFS, 16'h0003);
			rd(IRQ_STATUS_OFS);
			chk("status", v, 16'h0000);
			chk("req", stage_two_irq, 16'h0001);
		end
		// A higher source pending must hide this vector
		@(posedge sys_clk);
		higher_vector_pending <= 1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("vvalid", vector_valid, 16'h0000);
		chk("vec", vector_code, 16'h0000);
		@(posedge sys_clk);
		higher_vector_pending <= 0;
	endtask

	// Settings must keep acting while locked, though the register is wiped
	task t_lock;
		wr(CTRL_OFS, cf(2'h0, 3'h0, 1'b0, 3'h0, 1'b0));
		@(posedge sys_clk);
		low_power_pin_lock <= 1;
		repeat (2) @(posedge sys_clk);
		deepest_low_power_mode <= 1;
		repeat (3) @(posedge sys_clk);
		rd(CTRL_OFS);
		chk("ctrl", v, 16'h0100);
		pc = 0;
		tk(8, 1'b0);
		chk("pulses", 16'(pc), 16'h0004);
		wr(CTRL_OFS, cf(2'h0, 3'h1, 1'b0, 3'h0, 1'b0));
		pc = 0;
		tk(8, 1'b0);
		chk("pulses", 16'(pc), 16'h0004);
		@(posedge sys_clk);
		deepest_low_power_mode <= 0;
		low_power_pin_lock <= 0;
		pc = 0;
		tk(8, 1'b0);
		chk("pulses", 16'(pc), 16'h0002);
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk);
		reset_n <= 1;
		t_regs;
		t_source;
		t_divide;
		t_calendar;
		t_interval;
		t_lock;
		final_report;
	end
endmodule
